// ===== ssq_consts.svh
// Constants for the serial bit store sequencer
`ifndef SSQ_CONSTS_SVH
`define SSQ_CONSTS_SVH
// Address geometry: row (X) and column (Y) portions
`define SSQ_ROW_BITS 8
`define SSQ_COL_BITS 10
`define SSQ_SA_BITS 10
`define SSQ_COL_FIRST 10'h000
`define SSQ_COL_LAST 10'h3FF
// Clock and time figures
`define SSQ_CLK_NS 5
`define SSQ_REF_WIN_MS 100
`define SSQ_REF_ROWS 1024
`define SSQ_FAST_CYC_NS 400
`define SSQ_NORM_EXT_NS 2000
`define SSQ_NORM_SELF_NS 4000
`define SSQ_REF_BUSY 4'h4
// Counter widths
`define SSQ_TMR_BITS 16
`define SSQ_CYC_BITS 10
`define SSQ_BUSY_BITS 4
`define SSQ_FIFO_DEPTH 16
// Register offsets
`define SSQ_OFF_CTRL 8'h00
`define SSQ_OFF_STATUS 8'h04
`define SSQ_OFF_ERR 8'h08
`define SSQ_OFF_REFRESH 8'h0C
`define SSQ_OFF_SERADDR 8'h10
// Error bit positions
`define SSQ_ERR_OVF 0
`define SSQ_ERR_CYC 1
// Bus responses
`define SSQ_RESP_OK 2'h0
`define SSQ_RESP_SLVERR 2'h2
`endif

// ===== ssq_pkg.sv
// Types shared by the serial bit store sequencer
`include "ssq_consts.svh"
package ssq_pkg;
    typedef enum logic [1:0] {CMD_LOAD, CMD_ACC, CMD_RMW} ssq_kind_t;
    typedef enum logic {ENG_RUN, ENG_REFRESH} ssq_eng_t;
    typedef struct packed {
        ssq_kind_t kind;
        logic wr_n;
        logic din;
        logic up;
    } ssq_cmd_t;
    typedef struct packed {
        logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata;
        logic [3:0] wstrb; logic bready; logic arvalid; logic [7:0] araddr; logic rready;
    } ssq_axi_req_t;
    typedef struct packed {
        logic awready; logic wready; logic bvalid; logic [1:0] bresp;
        logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    } ssq_axi_rsp_t;
endpackage : ssq_pkg

// ===== ssq_fifo.sv
// Parameterised valid/ready FIFO for queued pin commands
module ssq_fifo #(
    parameter int W = 8,
    parameter int DEPTH = `SSQ_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_srst,
    // Fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    // Drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } ssq_fifo_st_t;
    ssq_fifo_st_t s_r, s_nxt;
    logic [W-1:0] mem_r [DEPTH];
    logic push, pop;

    // Honest full and empty from the fill count
    assign o_in_ready = (s_r.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (s_r.cnt != '0);
    assign o_out_data = mem_r[s_r.rd];
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;

    // Pointer and count update
    always_comb begin
        s_nxt = s_r;
        if (push) s_nxt.wr = s_r.wr + 1'b1;
        if (pop) s_nxt.rd = s_r.rd + 1'b1;
        if (push && !pop) s_nxt.cnt = s_r.cnt + 1'b1;
        else if (pop && !push) s_nxt.cnt = s_r.cnt - 1'b1;
    end

    // State register
    always_ff @(posedge i_core_clk) begin
        if (i_srst) s_r <= '0;
        else s_r <= s_nxt;
    end

    // Storage write
    always_ff @(posedge i_core_clk) begin
        if (push) mem_r[s_r.wr] <= i_in_data;
    end
endmodule : ssq_fifo

// ===== ssq_sequencer.sv
// Serial bit store sequencer: storage, address stepping, refresh, register slave
module ssq_sequencer import ssq_pkg::*; #(
    parameter int SELF_REF_CYC = (`SSQ_REF_WIN_MS * 1000000) / (`SSQ_REF_ROWS * `SSQ_CLK_NS),
    parameter int FIFO_DEPTH = `SSQ_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_srst,
    // Serial address pins
    input wire logic i_serial_start_addr_in,
    input wire logic i_addr_shift_strobe,
    input wire logic i_addr_load_strobe_n,
    // Access pins
    input wire logic i_access_clock_n,
    input wire logic i_write_en_n,
    input wire logic i_din,
    input wire logic i_chip_sel_n,
    input wire logic i_step_direction_sel,
    input wire logic i_fast_access_sel_n,
    // Refresh pins
    input wire logic i_refresh_source_sel,
    input wire logic i_ext_refresh_pulse_n,
    // Data output pin
    output logic o_dout,
    output logic o_dout_oe,
    // Register bus
    input wire ssq_axi_req_t i_axi,
    output ssq_axi_rsp_t o_axi
);
    localparam int AB = `SSQ_ROW_BITS + `SSQ_COL_BITS;
    localparam int WORDS = 1 << AB;
    localparam int FAST_MIN = (`SSQ_FAST_CYC_NS + `SSQ_CLK_NS - 1) / `SSQ_CLK_NS;
    localparam int EXT_MIN = (`SSQ_NORM_EXT_NS + `SSQ_CLK_NS - 1) / `SSQ_CLK_NS;
    localparam int SELF_MIN = (`SSQ_NORM_SELF_NS + `SSQ_CLK_NS - 1) / `SSQ_CLK_NS;

    typedef struct packed {
        logic p_shift; logic p_load_n; logic p_acc_n; logic p_we_n; logic p_ref_n;
        logic [`SSQ_SA_BITS-1:0] sa;
        logic [`SSQ_ROW_BITS-1:0] row;
        logic [`SSQ_COL_BITS-1:0] col;
        logic [AB-1:0] last;
        logic dir; logic fast; logic row_pend; logic oe; logic dout;
        ssq_eng_t eng;
        logic [`SSQ_BUSY_BITS-1:0] busy;
        logic [`SSQ_TMR_BITS-1:0] tmr;
        logic [`SSQ_ROW_BITS-1:0] ref_row;
        logic [15:0] ref_total;
        logic [`SSQ_CYC_BITS-1:0] cyc;
        logic pins_off; logic [1:0] err;
        logic aw_got; logic [7:0] awaddr; logic w_got; logic [31:0] wdata; logic [3:0] wstrb;
        logic bvalid; logic [1:0] bresp; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    } ssq_state_t;

    ssq_state_t s_r, s_nxt;
    logic mem_r [WORDS];
    logic mem_we, mem_wd;
    logic [AB-1:0] mem_wa;
    logic push, in_ready, out_valid, pop;
    ssq_cmd_t push_cmd, cmd;

    // Queue between the pin front end and the storage engine
    ssq_fifo #(.W($bits(ssq_cmd_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_in_valid(push),
        .o_in_ready(in_ready),
        .i_in_data(push_cmd),
        .o_out_valid(out_valid),
        .i_out_ready(s_r.eng == ENG_RUN),
        .o_out_data(cmd)
    );
    assign pop = out_valid & (s_r.eng == ENG_RUN);

    // Bus handshakes and registered pin outputs
    assign o_axi.awready = ~s_r.aw_got;
    assign o_axi.wready = ~s_r.w_got;
    assign o_axi.bvalid = s_r.bvalid;
    assign o_axi.bresp = s_r.bresp;
    assign o_axi.arready = ~s_r.rvalid;
    assign o_axi.rvalid = s_r.rvalid;
    assign o_axi.rdata = s_r.rdata;
    assign o_axi.rresp = s_r.rresp;
    assign o_dout = s_r.dout;
    assign o_dout_oe = s_r.oe;

    // Next-state logic for bus, pins, engine and refresh
    always_comb begin
        logic pins_ok, d, wrap;
        logic [31:0] rd;
        logic [`SSQ_CYC_BITS-1:0] cmin;
        logic [AB-1:0] addr;
        s_nxt = s_r;
        pins_ok = 1'b0;
        d = 1'b0;
        wrap = 1'b0;
        rd = '0;
        cmin = '0;
        addr = {s_r.row, s_r.col};
        mem_we = 1'b0;
        mem_wa = addr;
        mem_wd = 1'b0;
        push = 1'b0;
        push_cmd = '0;
        // Bus write path: address and data in either order
        if (i_axi.awvalid && !s_r.aw_got) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = i_axi.awaddr;
        end
        if (i_axi.wvalid && !s_r.w_got) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = i_axi.wdata;
            s_nxt.wstrb = i_axi.wstrb;
        end
        if (s_r.bvalid && i_axi.bready) s_nxt.bvalid = 1'b0;
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = `SSQ_RESP_OK;
            unique case ({s_r.awaddr[7:2], 2'b00})
                `SSQ_OFF_CTRL: if (s_r.wstrb[0]) s_nxt.pins_off = ~s_r.wdata[0];
                `SSQ_OFF_ERR: if (s_r.wstrb[0]) s_nxt.err = s_r.err & ~s_r.wdata[1:0];
                `SSQ_OFF_STATUS, `SSQ_OFF_REFRESH, `SSQ_OFF_SERADDR: ;
                default: s_nxt.bresp = `SSQ_RESP_SLVERR;
            endcase
        end
        // Bus read path
        if (s_r.rvalid && i_axi.rready) s_nxt.rvalid = 1'b0;
        if (i_axi.arvalid && !s_r.rvalid) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = `SSQ_RESP_OK;
            unique case ({i_axi.araddr[7:2], 2'b00})
                `SSQ_OFF_CTRL: rd = {31'h0000_0000, ~s_r.pins_off};
                `SSQ_OFF_STATUS: rd = {9'h000, s_r.eng, s_r.row_pend, s_r.oe, s_r.fast, s_r.dir, s_r.row, s_r.col};
                `SSQ_OFF_ERR: rd = {30'h0000_0000, s_r.err};
                `SSQ_OFF_REFRESH: rd = {s_r.ref_total, 8'h00, s_r.ref_row};
                `SSQ_OFF_SERADDR: rd = {22'h00_0000, s_r.sa};
                default: s_nxt.rresp = `SSQ_RESP_SLVERR;
            endcase
            s_nxt.rdata = rd;
        end
        // Pin sampling, edges are taken between consecutive samples
        s_nxt.p_shift = i_addr_shift_strobe;
        s_nxt.p_load_n = i_addr_load_strobe_n;
        s_nxt.p_acc_n = i_access_clock_n;
        s_nxt.p_we_n = i_write_en_n;
        s_nxt.p_ref_n = i_ext_refresh_pulse_n;
        if (s_r.cyc != '1) s_nxt.cyc = s_r.cyc + 1'b1;
        pins_ok = ~s_r.pins_off & ~i_chip_sel_n;
        if (pins_ok) begin
            if (i_addr_shift_strobe && !s_r.p_shift)
                s_nxt.sa = {i_serial_start_addr_in, s_r.sa[`SSQ_SA_BITS-1:1]};
            if (!i_access_clock_n)
                s_nxt.fast = ~i_fast_access_sel_n;
            if (!i_addr_load_strobe_n && s_r.p_load_n) begin
                push = 1'b1;
                push_cmd = '{kind: CMD_LOAD, wr_n: 1'b1, din: 1'b0, up: i_step_direction_sel};
            end else if (!i_access_clock_n && s_r.p_acc_n) begin
                // One queued access per access clock fall
                push = 1'b1;
                push_cmd = '{kind: CMD_ACC, wr_n: i_write_en_n, din: i_din, up: i_step_direction_sel};
                cmin = s_r.fast ? `SSQ_CYC_BITS'(FAST_MIN) :
                    (i_refresh_source_sel ? `SSQ_CYC_BITS'(EXT_MIN) : `SSQ_CYC_BITS'(SELF_MIN));
                if (s_r.cyc < cmin) s_nxt.err[`SSQ_ERR_CYC] = 1'b1;
                s_nxt.cyc = `SSQ_CYC_BITS'(1'b1); // Fall cycle counts as one
            end else if (!i_write_en_n && s_r.p_we_n && !i_access_clock_n) begin
                push = 1'b1;
                push_cmd = '{kind: CMD_RMW, wr_n: 1'b0, din: i_din, up: i_step_direction_sel};
            end
        end
        if (push && !in_ready) s_nxt.err[`SSQ_ERR_OVF] = 1'b1;
        // Storage engine drains one command per cycle
        if (pop) begin
            unique case (cmd.kind)
                CMD_LOAD: begin
                    s_nxt.row = s_r.sa[`SSQ_ROW_BITS-1:0];
                    s_nxt.col = cmd.up ? `SSQ_COL_FIRST : `SSQ_COL_LAST;
                    s_nxt.dir = cmd.up;
                    s_nxt.row_pend = 1'b0;
                end
                CMD_ACC: begin
                    d = s_r.fast ? s_r.dir : cmd.up;
                    s_nxt.dir = d;
                    s_nxt.last = addr;
                    if (cmd.wr_n) begin
                        s_nxt.dout = mem_r[addr];
                        s_nxt.oe = 1'b1;
                    end else begin
                        mem_we = 1'b1;
                        mem_wd = cmd.din;
                        s_nxt.oe = 1'b0;
                    end
                    // Sequential step by one
                    wrap = d ? (s_r.col == `SSQ_COL_LAST) : (s_r.col == `SSQ_COL_FIRST);
                    s_nxt.col = d ? s_r.col + 1'b1 : s_r.col - 1'b1;
                    if (s_r.fast) begin
                        if (wrap) s_nxt.row_pend = 1'b1;
                    end else if (wrap || s_r.row_pend) begin
                        s_nxt.row = d ? s_r.row + 1'b1 : s_r.row - 1'b1;
                        s_nxt.row_pend = 1'b0;
                    end
                end
                CMD_RMW: begin
                    mem_we = 1'b1;
                    mem_wa = s_r.last;
                    mem_wd = cmd.din;
                end
            endcase
        end
        // Refresh timer and row counter
        if (!i_refresh_source_sel) begin
            s_nxt.tmr = s_r.tmr + 1'b1;
            if (s_r.tmr == `SSQ_TMR_BITS'(SELF_REF_CYC - 1)) s_nxt.tmr = '0;
        end else begin
            s_nxt.tmr = '0;
        end
        unique case (s_r.eng)
            ENG_RUN: begin
                if ((!i_refresh_source_sel && s_r.tmr == `SSQ_TMR_BITS'(SELF_REF_CYC - 1)) ||
                    (i_refresh_source_sel && !s_r.pins_off && !i_ext_refresh_pulse_n &&
                     s_r.p_ref_n && i_access_clock_n)) begin
                    s_nxt.eng = ENG_REFRESH;
                    s_nxt.busy = `SSQ_REF_BUSY - 1'b1;
                end
            end
            ENG_REFRESH: begin
                s_nxt.busy = s_r.busy - 1'b1;
                if (s_r.busy == '0) begin
                    s_nxt.eng = ENG_RUN;
                    s_nxt.ref_row = s_r.ref_row + 1'b1;
                    s_nxt.ref_total = s_r.ref_total + 1'b1;
                end
            end
        endcase
        // Output floats when deselected or clock inactive
        if (i_chip_sel_n || (i_access_clock_n && s_r.p_acc_n)) s_nxt.oe = 1'b0;
    end

    // State register
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            s_r <= '0;
            s_r.p_shift <= 1'b1;
            s_r.p_load_n <= 1'b1;
            s_r.p_acc_n <= 1'b1;
            s_r.p_we_n <= 1'b1;
            s_r.p_ref_n <= 1'b1;
            s_r.cyc <= '1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Bit storage, written only through the sequential engine
    always_ff @(posedge i_core_clk) begin
        if (mem_we) mem_r[mem_wa] <= mem_wd;
    end

    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    chk_load_col_up: assert property (pop && cmd.kind == CMD_LOAD && cmd.up |=>
        s_r.col == `SSQ_COL_FIRST && s_r.row == $past(s_r.sa[`SSQ_ROW_BITS-1:0]))
        else $error("load did not set column zero");
    chk_load_col_dn: assert property (pop && cmd.kind == CMD_LOAD && !cmd.up |=>
        s_r.col == `SSQ_COL_LAST)
        else $error("load did not set last column");
    chk_step_by_one: assert property (pop && cmd.kind == CMD_ACC && s_nxt.dir &&
        s_r.col != `SSQ_COL_LAST |=> s_r.col == $past(s_r.col) + 1'b1)
        else $error("upward step not by one");
    chk_dir_follow: assert property (pop && cmd.kind == CMD_ACC && !s_r.fast |=>
        s_r.dir == $past(cmd.up))
        else $error("direction not taken from input");
    chk_dir_fast_hold: assert property (s_r.fast |=> s_r.dir == $past(s_r.dir))
        else $error("direction changed in fast access");
    chk_row_wrap_up: assert property (pop && cmd.kind == CMD_ACC && !s_r.fast &&
        s_nxt.dir && s_r.col == `SSQ_COL_LAST |=> s_r.col == `SSQ_COL_FIRST &&
        s_r.row == $past(s_r.row) + 1'b1)
        else $error("row did not advance at wrap");
    chk_write_store: assert property (pop && cmd.kind == CMD_ACC && !cmd.wr_n ##1 1'b1 |=>
        mem_r[$past(s_r.last)] == $past(cmd.din, 2))
        else $error("written bit not stored");
    chk_oe_desel: assert property (i_chip_sel_n |=> !o_dout_oe ##1 !o_dout_oe || !$past(i_chip_sel_n))
        else $error("output driven while deselected");
    chk_shift_addr: assert property (!s_r.pins_off && !i_chip_sel_n && i_addr_shift_strobe &&
        !s_r.p_shift |=> s_r.sa[`SSQ_SA_BITS-1] == $past(i_serial_start_addr_in))
        else $error("address bit not shifted in");
    chk_self_refresh: assert property (s_r.eng == ENG_RUN && !i_refresh_source_sel &&
        s_r.tmr == `SSQ_TMR_BITS'(SELF_REF_CYC - 1) |-> ##[4:5] s_r.ref_row == $past(s_r.ref_row, 4) + 1'b1)
        else $error("self refresh did not advance row");
endmodule : ssq_sequencer

// ===== ssq_ctl_model.sv
// Behavioural controller driving the store's pins
module ssq_ctl_model (
    // Clock
    input wire logic i_core_clk,
    // Read data back from the store
    input wire logic i_dout,
    input wire logic i_dout_oe,
    // Pins toward the store
    output logic o_serial_start_addr_in,
    output logic o_addr_shift_strobe,
    output logic o_addr_load_strobe_n,
    output logic o_access_clock_n,
    output logic o_write_en_n,
    output logic o_din,
    output logic o_chip_sel_n,
    output logic o_step_direction_sel,
    output logic o_fast_access_sel_n,
    output logic o_refresh_source_sel,
    output logic o_ext_refresh_pulse_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle levels at time zero, external refresh chosen
    initial begin
        {o_serial_start_addr_in, o_din, o_chip_sel_n, o_step_direction_sel} = 4'h0;
        {o_addr_shift_strobe, o_addr_load_strobe_n, o_access_clock_n} = 3'h7;
        {o_write_en_n, o_fast_access_sel_n, o_refresh_source_sel, o_ext_refresh_pulse_n} = 4'hF;
    end

    // Wait a number of clock edges
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask : tick

    // Shift ten address bits, lowest first
    task automatic shift_addr(input logic [9:0] a);
        for (int i = 0; i < 10; i++) begin
            o_serial_start_addr_in <= a[i];
            o_addr_shift_strobe <= 1'b0;
            tick(2);
            o_addr_shift_strobe <= 1'b1;
            tick(2);
        end
    endtask : shift_addr

    // Set direction, then pulse the load strobe
    task automatic load(input logic up);
        o_step_direction_sel <= up;
        tick(2);
        o_addr_load_strobe_n <= 1'b0;
        tick(2);
        o_addr_load_strobe_n <= 1'b1;
        tick(2);
    endtask : load

    // One access clock cycle; rmw and set_fast drive their own clock edges
    task automatic access(input logic we_n, input logic d, input int lo, input int hi,
                          output logic q, output logic oe);
        o_write_en_n <= we_n;
        o_din <= d;
        o_access_clock_n <= 1'b0;
        tick(lo);
        q = i_dout;
        oe = i_dout_oe;
        o_access_clock_n <= 1'b1;
        tick(hi);
    endtask : access

    // Read, then drop write enable while the clock is low
    task automatic rmw(input logic d, output logic q);
        o_write_en_n <= 1'b1;
        o_access_clock_n <= 1'b0;
        tick(100);
        q = i_dout;
        o_write_en_n <= 1'b0;
        o_din <= d;
        tick(100);
        o_access_clock_n <= 1'b1;
        o_write_en_n <= 1'b1;
        tick(200);
    endtask : rmw

    // Switch fast mode only inside a low clock phase
    task automatic set_fast(input logic fast_n);
        o_access_clock_n <= 1'b0;
        tick(200);
        o_fast_access_sel_n <= fast_n;
        tick(200);
        o_access_clock_n <= 1'b1;
        tick(200);
    endtask : set_fast

    // Static mode pins
    task automatic set_pins(input logic cs_n, input logic dir, input logic src);
        o_chip_sel_n <= cs_n;
        o_step_direction_sel <= dir;
        o_refresh_source_sel <= src;
        tick(2);
    endtask : set_pins

    // One external refresh pulse, access clock held high
    task automatic refresh_pulse();
        o_ext_refresh_pulse_n <= 1'b0;
        tick(4);
        o_ext_refresh_pulse_n <= 1'b1;
        tick(4);
    endtask : refresh_pulse
endmodule : ssq_ctl_model

// ===== ssq_tb.sv
// Self-checking testbench for the serial bit store sequencer
`include "ssq_consts.svh"
module testbench import ssq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic [7:0] a; logic [31:0] exp; logic [31:0] mask; logic [1:0] resp;} ssq_row_t;
    logic i_core_clk;
    logic i_srst;
    ssq_axi_req_t axi_req;
    ssq_axi_rsp_t axi_rsp;
    logic sa_bit, sa_shift, sa_load_n, acc_n, we_n, din, cs_n, dir, fast_n, rsrc, ext_refresh_pulse_n, dout, dout_oe;
    int num_errors = 0;
    int compares = 0;
    logic [31:0] d, t0;
    logic [1:0] r;
    logic q, oe;
    ssq_row_t rows [5] = '{
        '{`SSQ_OFF_CTRL, 32'h00000001, 32'hFFFFFFFF, `SSQ_RESP_OK},
        '{`SSQ_OFF_STATUS, 32'h00000000, 32'h000FFFFF, `SSQ_RESP_OK},
        '{`SSQ_OFF_ERR, 32'h00000000, 32'h00000003, `SSQ_RESP_OK},
        '{`SSQ_OFF_SERADDR, 32'h00000000, 32'h000003FF, `SSQ_RESP_OK},
        '{8'h14, 32'h00000000, 32'h00000000, `SSQ_RESP_SLVERR}};
    logic [3:0] pat = 4'hB;

    // Design and controller
    ssq_sequencer #(.SELF_REF_CYC(20), .FIFO_DEPTH(16)) dut_u (.i_core_clk(i_core_clk), .i_srst(i_srst),
        .i_serial_start_addr_in(sa_bit), .i_addr_shift_strobe(sa_shift), .i_addr_load_strobe_n(sa_load_n),
        .i_access_clock_n(acc_n), .i_write_en_n(we_n), .i_din(din), .i_chip_sel_n(cs_n),
        .i_step_direction_sel(dir), .i_fast_access_sel_n(fast_n), .i_refresh_source_sel(rsrc),
        .i_ext_refresh_pulse_n(ext_refresh_pulse_n), .o_dout(dout), .o_dout_oe(dout_oe), .i_axi(axi_req), .o_axi(axi_rsp));
    ssq_ctl_model ctl_u (.i_core_clk(i_core_clk), .i_dout(dout), .i_dout_oe(dout_oe),
        .o_serial_start_addr_in(sa_bit), .o_addr_shift_strobe(sa_shift), .o_addr_load_strobe_n(sa_load_n),
        .o_access_clock_n(acc_n), .o_write_en_n(we_n), .o_din(din), .o_chip_sel_n(cs_n),
        .o_step_direction_sel(dir), .o_fast_access_sel_n(fast_n), .o_refresh_source_sel(rsrc),
        .o_ext_refresh_pulse_n(ext_refresh_pulse_n));

    // 200 MHz clock
    initial begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk

    // Bus read, valid held until taken
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rr);
        @(posedge i_core_clk);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= a;
        axi_req.rready <= 1'b1;
        do @(posedge i_core_clk); while (axi_rsp.arready !== 1'b1);
        axi_req.arvalid <= 1'b0;
        while (axi_rsp.rvalid !== 1'b1) @(posedge i_core_clk);
        rd = axi_rsp.rdata;
        rr = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
    endtask : axi_rd

    // Bus write, address and data offered together
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s, output logic [1:0] br);
        logic aw_done;
        logic w_done;
        @(posedge i_core_clk);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= a;
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= wd;
        axi_req.wstrb <= s;
        axi_req.bready <= 1'b1;
        aw_done = 1'b0;
        w_done = 1'b0;
        do begin
            @(posedge i_core_clk);
            if (!aw_done && axi_rsp.awready === 1'b1) begin
                aw_done = 1'b1;
                axi_req.awvalid <= 1'b0;
            end
            if (!w_done && axi_rsp.wready === 1'b1) begin
                w_done = 1'b1;
                axi_req.wvalid <= 1'b0;
            end
        end while (!(aw_done && w_done));
        while (axi_rsp.bvalid !== 1'b1) @(posedge i_core_clk);
        br = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
    endtask : axi_wr

    // Verdict and end of run
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize

    // Watchdog against a hang
    initial begin
        repeat (60000) @(posedge i_core_clk);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end

    // Main sequence
    initial begin
        i_srst = 1'b1;
        axi_req = '0;
        repeat (2) @(posedge i_core_clk);
        i_srst <= 1'b0;
        // Register reset values and unmapped address
        foreach (rows[i]) begin
            axi_rd(rows[i].a, d, r);
            chk(d & rows[i].mask, rows[i].exp, "reg value");
            chk(r, rows[i].resp, "reg resp");
        end
        $display("done: reset registers");
        // Serial address then load going up
        ctl_u.shift_addr(10'h0A5);
        axi_rd(`SSQ_OFF_SERADDR, d, r);
        chk(d & 32'h3FF, 32'h0A5, "shift reg");
        ctl_u.load(1'b1);
        axi_rd(`SSQ_OFF_STATUS, d, r);
        chk(d & 32'h7FFFF, {13'h0, 1'b1, 8'hA5, 10'h000}, "load up");
        $display("done: address load");
        // Write four bits, reload, read them back
        for (int i = 0; i < 4; i++) ctl_u.access(1'b0, pat[i], 200, 200, q, oe);
        chk(dout_oe, 1'b0, "oe on write");
        axi_rd(`SSQ_OFF_STATUS, d, r);
        chk(d & 32'h3FF, 32'h4, "col after writes");
        ctl_u.load(1'b1);
        for (int i = 0; i < 4; i++) begin
            ctl_u.access(1'b1, 1'b0, 200, 200, q, oe);
            chk(q, pat[i], "read bit");
            chk(oe, 1'b1, "oe on read");
        end
        chk(dout_oe, 1'b0, "oe after clock high");
        $display("done: write read");
        // Read-modify-write at column 0
        ctl_u.load(1'b1);
        ctl_u.rmw(1'b0, q);
        chk(q, 1'b1, "rmw read");
        ctl_u.load(1'b1);
        ctl_u.access(1'b1, 1'b0, 200, 200, q, oe);
        chk(q, 1'b0, "rmw stored");
        axi_rd(`SSQ_OFF_ERR, d, r);
        chk(d & 32'h3, 32'h0, "legal cycles");
        $display("done: rmw");
        // Load going down, step down
        ctl_u.load(1'b0);
        axi_rd(`SSQ_OFF_STATUS, d, r);
        chk(d & 32'h7FFFF, {14'h0, 8'hA5, 10'h3FF}, "load down");
        ctl_u.access(1'b1, 1'b0, 200, 200, q, oe);
        axi_rd(`SSQ_OFF_STATUS, d, r);
        chk(d & 32'h3FF, 32'h3FE, "step down");
        $display("done: down");
        // Fast mode ignores a direction change
        ctl_u.set_fast(1'b0);
        ctl_u.set_pins(1'b0, 1'b1, 1'b1);
        ctl_u.access(1'b1, 1'b0, 40, 40, q, oe);
        axi_rd(`SSQ_OFF_STATUS, d, r);
        chk(d & 32'hC03FF, 32'h803FC, "fast keeps down");
        ctl_u.set_fast(1'b1);
        axi_rd(`SSQ_OFF_STATUS, d, r);
        chk(d & 32'h80000, 32'h0, "fast off");
        $display("done: fast");
        // Full row of short cycles steps the row
        ctl_u.load(1'b1);
        for (int i = 0; i < 1024; i++) ctl_u.access(1'b0, 1'b0, 2, 2, q, oe);
        ctl_u.tick(40);
        axi_rd(`SSQ_OFF_STATUS, d, r);
        chk(d & 32'h3FFFF, {14'h0, 8'hA6, 10'h000}, "row step");
        axi_rd(`SSQ_OFF_ERR, d, r);
        chk(d & 32'h2, 32'h2, "short cycle flag");
        axi_wr(`SSQ_OFF_ERR, 32'h00000003, 4'hF, r);
        axi_rd(`SSQ_OFF_ERR, d, r);
        chk(d & 32'h3, 32'h0, "err cleared");
        axi_wr(8'h14, 32'h00000000, 4'hF, r);
        chk(r, `SSQ_RESP_SLVERR, "unmapped write");
        $display("done: row step");
        // Deselected and disabled pins are ignored
        ctl_u.set_pins(1'b1, 1'b1, 1'b1);
        ctl_u.access(1'b1, 1'b0, 200, 200, q, oe);
        chk(oe, 1'b0, "oe deselected");
        ctl_u.set_pins(1'b0, 1'b1, 1'b1);
        axi_wr(`SSQ_OFF_CTRL, 32'h00000000, 4'hE, r);
        axi_rd(`SSQ_OFF_CTRL, d, r);
        chk(d, 32'h1, "strobe off ignored");
        axi_wr(`SSQ_OFF_CTRL, 32'h00000000, 4'hF, r);
        chk(r, `SSQ_RESP_OK, "ctrl write resp");
        ctl_u.access(1'b1, 1'b0, 200, 200, q, oe);
        chk(oe, 1'b0, "oe disabled");
        axi_wr(`SSQ_OFF_CTRL, 32'h00000001, 4'hF, r);
        ctl_u.access(1'b1, 1'b0, 200, 200, q, oe);
        axi_rd(`SSQ_OFF_STATUS, d, r);
        chk(d & 32'h3FF, 32'h1, "only enabled access steps");
        $display("done: select");
        // External pulses, then self refresh timer
        axi_rd(`SSQ_OFF_REFRESH, t0, r);
        repeat (3) ctl_u.refresh_pulse();
        ctl_u.tick(20);
        axi_rd(`SSQ_OFF_REFRESH, d, r);
        chk(d[31:16], t0[31:16] + 16'h0003, "ext refresh count");
        ctl_u.set_pins(1'b0, 1'b1, 1'b0);
        ctl_u.tick(200);
        axi_rd(`SSQ_OFF_REFRESH, t0, r);
        chk(32'(t0[31:16] - d[31:16] >= 16'h0008), 32'h1, "self refresh count");
        $display("done: refresh");
        // Mid-run reset returns state to idle
        i_srst <= 1'b1;
        ctl_u.tick(2);
        i_srst <= 1'b0;
        axi_rd(`SSQ_OFF_STATUS, d, r);
        chk(d, 32'h0, "status after reset");
        axi_rd(`SSQ_OFF_REFRESH, d, r);
        chk(d, 32'h0, "refresh after reset");
        $display("done: mid reset");
        summarize();
    end
endmodule : testbench
